// file: src/window_switch_channel_hysteresis.sv
/*
 * Switching channel with two setpoints and hysteresis bands.
 * Assumes count pulses and bus strobes come from logic on clk.
 */
`timescale 1ns/1ns
module window_switch_channel_hysteresis (
    input wire logic clk,
    input wire logic reset,
    input wire logic count_up,
    input wire logic count_down,
    input wire win_switch_pkg::bus_req_t bus,
    output logic [31:0] rdata,
    output logic irq,
    output logic switching_channel_one,
    output logic [15:0] measured_position_channel
);
    ////////////////////////////////////////////////////////////////////
    // Helper arithmetic
    // Add with a ceiling
    function automatic logic [15:0] add_clamp(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic [15:0] lim
    );
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum > {1'b0, lim}) begin
            add_clamp = lim;
        end else begin
            add_clamp = sum[15:0];
        end
    endfunction

    // Subtract with a floor of zero
    function automatic logic [15:0] sub_clamp(
        input logic [15:0] a,
        input logic [15:0] b
    );
        if (b > a) begin
            sub_clamp = 16'h0000;
        end else begin
            sub_clamp = a - b;
        end
    endfunction

    // Setpoint beyond the wrap limit acts at the limit
    function automatic logic [15:0] sp_clamp(
        input logic [15:0] sp,
        input logic [15:0] lim
    );
        sp_clamp = (sp > lim) ? lim : sp;
    endfunction

    // Sector of a position for the given settings
    function automatic win_switch_pkg::sector_t classify(
        input logic [15:0] p,
        input win_switch_pkg::state_t c
    );
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] hl;
        logic [15:0] hh;
        logic [15:0] lo_edge;
        logic [15:0] hi_edge;
        lo = sp_clamp(c.sp1, c.wrap);
        hi = sp_clamp(c.sp2, c.wrap);
        hl = c.h1;
        hh = c.h2;
        if (c.mode) begin
            // Single point: window runs from zero up to setpoint one
            hi = lo;
            hh = c.h1;
            lo = 16'h0000;
            hl = 16'h0000;
        end else if (lo > hi) begin
            // Larger value is the upper limit whatever its number
            lo = sp_clamp(c.sp2, c.wrap);
            hi = sp_clamp(c.sp1, c.wrap);
            hl = c.h2;
            hh = c.h1;
        end
        // Bands lie outside the window, each with its own width
        lo_edge = sub_clamp(lo, hl);
        hi_edge = add_clamp(hi, hh, c.wrap);
        if (p >= lo && p <= hi) begin
            classify = win_switch_pkg::SEC_INNER;
        end else if (p < lo && p >= lo_edge) begin
            classify = win_switch_pkg::SEC_LOW_BAND;
        end else if (p > hi && p <= hi_edge) begin
            classify = win_switch_pkg::SEC_HIGH_BAND;
        end else begin
            classify = win_switch_pkg::SEC_OUTSIDE;
        end
    endfunction

    // Next raw level from sector left, sector entered and old level
    function automatic logic next_raw(
        input win_switch_pkg::sector_t from,
        input win_switch_pkg::sector_t to,
        input logic old
    );
        logic from_band;
        from_band = (from == win_switch_pkg::SEC_LOW_BAND)
            || (from == win_switch_pkg::SEC_HIGH_BAND);
        next_raw = old;
        if (from_band && to == win_switch_pkg::SEC_INNER) begin
            next_raw = 1'b0;
        end else if (from_band && to == win_switch_pkg::SEC_OUTSIDE) begin
            next_raw = 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State
    win_switch_pkg::state_t s_r; // Registered state
    win_switch_pkg::state_t s_nxt; // Next state
    win_switch_pkg::sector_t new_sec; // Sector of the new sample
    logic step; // New position sample this cycle
    logic [1:0] ev; // Events raised this cycle
    logic [1:0] clr; // Status bits cleared this cycle

    assign step = count_up ^ count_down;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        ev = 2'b00;
        clr = 2'b00;
        new_sec = s_r.sector;
        // Position counter: up past the limit wraps to zero, down from zero wraps to the limit
        if (step && count_up) begin
            if (s_r.pos >= s_r.wrap) begin
                s_nxt.pos = 16'h0000;
            end else begin
                s_nxt.pos = s_r.pos + 16'h0001;
            end
        end else if (step) begin
            if (s_r.pos == 16'h0000) begin
                s_nxt.pos = s_r.wrap;
            end else begin
                s_nxt.pos = s_r.pos - 16'h0001;
            end
        end
        // Sector tracking once per sample
        if (step) begin
            new_sec = classify(s_nxt.pos, s_r);
            s_nxt.sector = new_sec;
            s_nxt.primed = 1'b1;
            if (!s_r.primed) begin
                // First sample: level follows where we stand
                s_nxt.raw = (new_sec != win_switch_pkg::SEC_INNER);
            end else begin
                s_nxt.raw = next_raw(s_r.sector, new_sec, s_r.raw);
            end
            ev[win_switch_pkg::IRQ_LEVEL_BIT] = s_nxt.raw != s_r.raw;
            ev[win_switch_pkg::IRQ_SECTOR_BIT] = new_sec != s_r.sector;
        end
        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                win_switch_pkg::REG_CTRL: begin
                    s_nxt.pol = bus.wdata[win_switch_pkg::CTRL_POL_BIT];
                    s_nxt.mode = bus.wdata[win_switch_pkg::CTRL_MODE_BIT];
                end
                win_switch_pkg::REG_SP_ONE: s_nxt.sp1 = bus.wdata[15:0];
                win_switch_pkg::REG_SP_TWO: s_nxt.sp2 = bus.wdata[15:0];
                win_switch_pkg::REG_HYST_ONE: s_nxt.h1 = bus.wdata[15:0];
                win_switch_pkg::REG_HYST_TWO: s_nxt.h2 = bus.wdata[15:0];
                win_switch_pkg::REG_WRAP: s_nxt.wrap = bus.wdata[15:0];
                win_switch_pkg::REG_IRQ_CLEAR: clr = bus.wdata[1:0];
                win_switch_pkg::REG_IRQ_ENABLE: s_nxt.irq_en = bus.wdata[1:0];
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
        // Sticky status, a new event wins over a clear
        s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
        // Read data for the next cycle only
        s_nxt.rdata = 32'h0000_0000;
        if (bus.rd) begin
            case (bus.addr)
                win_switch_pkg::REG_CTRL: s_nxt.rdata = {30'h0, s_r.mode, s_r.pol};
                win_switch_pkg::REG_SP_ONE: s_nxt.rdata = {16'h0, s_r.sp1};
                win_switch_pkg::REG_SP_TWO: s_nxt.rdata = {16'h0, s_r.sp2};
                win_switch_pkg::REG_HYST_ONE: s_nxt.rdata = {16'h0, s_r.h1};
                win_switch_pkg::REG_HYST_TWO: s_nxt.rdata = {16'h0, s_r.h2};
                win_switch_pkg::REG_WRAP: s_nxt.rdata = {16'h0, s_r.wrap};
                win_switch_pkg::REG_POSITION: s_nxt.rdata = {16'h0, s_r.pos};
                win_switch_pkg::REG_STATE: begin
                    s_nxt.rdata = {27'h0, s_r.primed, s_r.sw_out, s_r.raw, s_r.sector};
                end
                win_switch_pkg::REG_IRQ_STATUS: s_nxt.rdata = {30'h0, s_r.irq_st};
                win_switch_pkg::REG_IRQ_ENABLE: s_nxt.rdata = {30'h0, s_r.irq_en};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // Registered outputs
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
        s_nxt.sw_out = s_nxt.raw ^ s_nxt.pol;
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '{
                pos: 16'h0000,
                sector: win_switch_pkg::SEC_OUTSIDE,
                raw: 1'b0,
                primed: 1'b0,
                pol: 1'b0,
                mode: 1'b0,
                sp1: win_switch_pkg::SP_RST,
                sp2: win_switch_pkg::SP_RST,
                h1: win_switch_pkg::HYST_RST,
                h2: win_switch_pkg::HYST_RST,
                wrap: win_switch_pkg::WRAP_RST,
                irq_st: 2'h0,
                irq_en: 2'h0,
                rdata: 32'h0000_0000,
                irq: 1'b0,
                sw_out: 1'b0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign irq = s_r.irq;
    assign switching_channel_one = s_r.sw_out;
    assign measured_position_channel = s_r.pos;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Counting up past the limit restarts at zero
    a_wrap_to_zero: assert property (
        count_up && !count_down && s_r.pos >= s_r.wrap |=> s_r.pos == 16'h0000)
        else $error("position did not restart at zero");

    a_inner_clears: assert property (
        step && s_r.primed && s_r.raw
        && (s_r.sector == win_switch_pkg::SEC_LOW_BAND)
        && new_sec == win_switch_pkg::SEC_INNER |=> !s_r.raw)
        else $error("inner entry from low band kept level high");

    a_upper_band_in: assert property (
        step && s_r.primed && s_r.raw
        && (s_r.sector == win_switch_pkg::SEC_HIGH_BAND)
        && new_sec == win_switch_pkg::SEC_INNER
        |=> !s_r.raw && s_r.sw_out == s_r.pol)
        else $error("inner entry from upper band kept level high");

    a_outer_sets: assert property (
        step && s_r.primed && !s_r.raw && s_r.sector != win_switch_pkg::SEC_INNER
        && s_r.sector != win_switch_pkg::SEC_OUTSIDE
        && new_sec == win_switch_pkg::SEC_OUTSIDE |=> s_r.raw)
        else $error("outer entry from band kept level low");

    a_level_holds: assert property (
        (step && s_r.primed && (s_r.sector == win_switch_pkg::SEC_INNER
        || s_r.sector == win_switch_pkg::SEC_OUTSIDE)) || (!step && s_r.primed)
        |=> $stable(s_r.raw))
        else $error("level changed without a band exit");

    a_polarity_out: assert property (
        bus.wr && bus.addr == win_switch_pkg::REG_CTRL && !step
        |=> switching_channel_one == ($past(s_r.raw) ^ s_r.pol))
        else $error("output ignores polarity");

    // Limit itself lies in an upper band that reaches past it
    a_upper_clamp: assert property (
        step && s_r.primed && !s_r.mode && s_nxt.pos == s_r.wrap
        && s_r.sp1 < s_r.wrap && s_r.sp2 < s_r.wrap
        && ((s_r.sp1 > s_r.sp2) ? {1'b0, s_r.sp1} + {1'b0, s_r.h1}
        : {1'b0, s_r.sp2} + {1'b0, s_r.h2}) >= {1'b0, s_r.wrap}
        |=> s_r.sector == win_switch_pkg::SEC_HIGH_BAND)
        else $error("wrap limit not inside upper band");

    // Zero lies in a lower band that reaches below it
    a_lower_clamp: assert property (
        step && !s_r.mode && s_nxt.pos == 16'h0000 && s_r.sp1 != 16'h0000
        && s_r.wrap != 16'h0000
        && s_r.sp2 != 16'h0000 && s_r.h1 >= s_r.sp1 && s_r.h2 >= s_r.sp2
        |=> s_r.sector == win_switch_pkg::SEC_LOW_BAND)
        else $error("zero not inside lower band");

    a_irq_raise: assert property (
        step && s_nxt.raw != s_r.raw && s_r.irq_en[win_switch_pkg::IRQ_LEVEL_BIT]
        && !(bus.wr && bus.addr == win_switch_pkg::REG_IRQ_ENABLE)
        |=> irq && s_r.irq_st[win_switch_pkg::IRQ_LEVEL_BIT])
        else $error("level event did not raise interrupt");

    a_read_pos: assert property (
        bus.rd && bus.addr == win_switch_pkg::REG_POSITION
        |=> rdata == {16'h0, $past(s_r.pos)} ##1 rdata == 32'h0 || $past(bus.rd))
        else $error("position read data wrong");

    // Both pulses at once leave the position alone
    a_both_ignored: assert property (
        count_up && count_down |=> $stable(s_r.pos))
        else $error("position moved on a double pulse");

    // Sector is only re-evaluated on a step
    a_sector_on_step: assert property (
        !step |=> $stable(s_r.sector))
        else $error("sector changed without a step");

    // A sector event survives a clear in the same cycle
    a_event_beats_clear: assert property (
        step && new_sec != s_r.sector
        |=> s_r.irq_st[win_switch_pkg::IRQ_SECTOR_BIT])
        else $error("sector event lost against a clear");

    // First sample after reset: level follows the sector
    a_first_level: assert property (
        step && !s_r.primed
        |=> s_r.raw == (s_r.sector != win_switch_pkg::SEC_INNER))
        else $error("first level does not match the sector");

    // Single point mode has no lower band
    a_single_no_low: assert property (
        step && s_r.mode |=> s_r.sector != win_switch_pkg::SEC_LOW_BAND)
        else $error("lower band seen in single point mode");

    // Whole span between the setpoints is inner, whichever is larger
    a_inner_span: assert property (
        step && !s_r.mode && s_r.sp1 <= s_r.wrap && s_r.sp2 <= s_r.wrap
        && ((s_nxt.pos >= s_r.sp1 && s_nxt.pos <= s_r.sp2)
        || (s_nxt.pos >= s_r.sp2 && s_nxt.pos <= s_r.sp1))
        |=> s_r.sector == win_switch_pkg::SEC_INNER)
        else $error("position between setpoints not inner");

    // Main scenarios
    c_window_exit: cover property (
        step && s_r.sector == win_switch_pkg::SEC_HIGH_BAND
        && new_sec == win_switch_pkg::SEC_OUTSIDE && !s_r.raw);
    c_single_point: cover property (s_r.mode && step && s_nxt.raw != s_r.raw);
    c_wrap: cover property (count_up && !count_down && s_r.pos >= s_r.wrap);
    c_upper_clamp: cover property (
        step && s_nxt.pos == s_r.wrap && new_sec == win_switch_pkg::SEC_HIGH_BAND);
    c_double_pulse: cover property (count_up && count_down);
endmodule // window_switch_channel_hysteresis

// file: src/win_switch_pkg.sv
/*
 * Constants, types and register map of the window switching channel.
 * Assumes one 100 MHz clock shared by the bus master and position logic.
 */
// How it works
// - each setpoint has its own hysteresis width
// - window bands extend outward past window edges
// - band beyond wrap limit is legal configuration
// - upper band edge clamps to wrap limit
// - next level uses left sector and old level
// - band to inner clears, band to outside sets, else hold
// - larger band into inner while high goes low
// - polarity select inverts the switching output
// - single point mode uses same sector logic
// - counting past wrap limit restarts at zero
// - larger setpoint is upper limit, smaller lower
// - lower band edge clamps at zero
package win_switch_pkg;
    ////////////////////////////////////////////////////////////////////
    // Widths
    localparam int POS_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int IRQ_W = 2;
    ////////////////////////////////////////////////////////////////////
    // Register word addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SP_ONE = 4'h1;
    localparam logic [3:0] REG_SP_TWO = 4'h2;
    localparam logic [3:0] REG_HYST_ONE = 4'h3;
    localparam logic [3:0] REG_HYST_TWO = 4'h4;
    localparam logic [3:0] REG_WRAP = 4'h5;
    localparam logic [3:0] REG_POSITION = 4'h6;
    localparam logic [3:0] REG_STATE = 4'h7;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h9;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'ha;
    ////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int IRQ_LEVEL_BIT = 0;
    localparam int IRQ_SECTOR_BIT = 1;
    localparam logic [15:0] WRAP_RST = 16'hffff;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h0000;
    ////////////////////////////////////////////////////////////////////
    // Position sectors
    typedef enum logic [1:0] {
        SEC_OUTSIDE,
        SEC_LOW_BAND,
        SEC_INNER,
        SEC_HIGH_BAND
    } sector_t;
    // Register bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [31:0] wdata;
    } bus_req_t;
    // Whole block state
    typedef struct packed {
        logic [15:0] pos;
        sector_t sector;
        logic raw;
        logic primed;
        logic pol;
        logic mode;
        logic [15:0] sp1;
        logic [15:0] sp2;
        logic [15:0] h1;
        logic [15:0] h2;
        logic [15:0] wrap;
        logic [1:0] irq_st;
        logic [1:0] irq_en;
        logic [31:0] rdata;
        logic irq;
        logic sw_out;
    } state_t;
endpackage

// file: verification/link_master_model.sv
/*
 * Link master model: polls the switching output as process data.
 * Assumes the channel's clock and reset.
 */
`timescale 1ns/1ns
module link_master_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic sw_in,
    output logic [7:0] edges
);
    logic last_r; // Level seen at the previous poll
    // Count level changes between polls
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_r <= 1'b0;
            edges <= 8'h00;
        end else begin
            last_r <= sw_in;
            if (sw_in != last_r) begin
                edges <= edges + 8'h01;
            end
        end
    end
endmodule // link_master_model

// file: verification/test_window_switch_channel_hysteresis.sv
/*
 * Self-checking bench of the window switching channel.
 * Assumes the package, the channel and the link master model compile first.
 */
`timescale 1ns/1ns
module test_window_switch_channel_hysteresis;
    logic clk; // 100 MHz clock
    logic reset; // Async reset
    logic count_up; // Step up pulse
    logic count_down; // Step down pulse
    win_switch_pkg::bus_req_t bus; // Register request
    logic [31:0] rdata; // Read data
    logic irq; // Interrupt level
    logic sw; // Switching output
    logic [15:0] pos; // Position
    logic [7:0] edges; // Changes seen by the master
    int err_total; // Mismatches
    int num_checks; // Comparisons
    int cyc; // Cycles run

    window_switch_channel_hysteresis i_window_switch_channel_hysteresis (
        .clk(clk),
        .reset(reset),
        .count_up(count_up),
        .count_down(count_down),
        .bus(bus),
        .rdata(rdata),
        .irq(irq),
        .switching_channel_one(sw),
        .measured_position_channel(pos)
    );
    link_master_model i_link_master_model (
        .clk(clk),
        .reset(reset),
        .sw_in(sw),
        .edges(edges)
    );
    ////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            test_done();
        end
    end
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            err_total = err_total + 1;
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // One-cycle read, data checked in the following cycle
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    // Steps in one direction, then check the output
    task automatic sc(input logic up, input int n, input logic e);
        repeat (n) begin
            @(posedge clk);
            count_up <= up;
            count_down <= ~up;
            @(posedge clk);
            count_up <= 1'b0;
            count_down <= 1'b0;
        end
        #1;
        chk("switch", {31'h0, e}, {31'h0, sw});
    endtask
    ////////////////////////////////////////////////////////////
    // Reset values, read-only and unmapped places
    task automatic t_reset();
        rdchk("wrap", win_switch_pkg::REG_WRAP, 32'hffff);
        rdchk("sp one", win_switch_pkg::REG_SP_ONE, 32'h0);
        rdchk("hyst two", win_switch_pkg::REG_HYST_TWO, 32'h0);
        wr(win_switch_pkg::REG_POSITION, 32'h55);
        rdchk("position", win_switch_pkg::REG_POSITION, 32'h0);
        rdchk("unmapped", 4'hf, 32'h0);
        $display("reset test done");
    endtask
    // Window 10..20, bands 2 below and 3 above
    task automatic t_window();
        wr(win_switch_pkg::REG_SP_ONE, 32'h14);
        wr(win_switch_pkg::REG_SP_TWO, 32'h0a);
        wr(win_switch_pkg::REG_HYST_ONE, 32'h3);
        wr(win_switch_pkg::REG_HYST_TWO, 32'h2);
        sc(1'b1, 1, 1'b1);
        sc(1'b1, 7, 1'b1);
        sc(1'b1, 2, 1'b0);
        sc(1'b0, 1, 1'b0);
        sc(1'b0, 2, 1'b1);
        sc(1'b1, 2, 1'b1);
        sc(1'b1, 12, 1'b0);
        sc(1'b1, 2, 1'b0);
        sc(1'b1, 1, 1'b1);
        sc(1'b0, 1, 1'b1);
        sc(1'b0, 3, 1'b0);
        @(posedge clk);
        #1;
        chk("edges", 32'h6, {24'h0, edges});
        chk("position", 32'h14, {16'h0, pos});
        $display("window test done");
    endtask
    // Upper band past the wrap limit, then wrap to zero
    task automatic t_wrap();
        wr(win_switch_pkg::REG_WRAP, 32'h1e);
        wr(win_switch_pkg::REG_HYST_ONE, 32'h14);
        rdchk("hyst one", win_switch_pkg::REG_HYST_ONE, 32'h14);
        sc(1'b1, 10, 1'b0);
        chk("position", 32'h1e, {16'h0, pos});
        sc(1'b1, 1, 1'b1);
        chk("position", 32'h0, {16'h0, pos});
        $display("wrap test done");
    endtask
    // Lower band below zero reaches down to zero
    task automatic t_zero();
        wr(win_switch_pkg::REG_HYST_TWO, 32'hf);
        sc(1'b1, 1, 1'b1);
        sc(1'b1, 9, 1'b0);
        sc(1'b0, 10, 1'b0);
        $display("zero test done");
    endtask
    // Inverted polarity, then single point mode
    task automatic t_modes();
        wr(win_switch_pkg::REG_HYST_TWO, 32'h2);
        wr(win_switch_pkg::REG_CTRL, 32'h1);
        sc(1'b1, 10, 1'b1);
        sc(1'b0, 3, 1'b0);
        wr(win_switch_pkg::REG_CTRL, 32'h2);
        wr(win_switch_pkg::REG_WRAP, 32'hff);
        sc(1'b1, 34, 1'b1);
        sc(1'b0, 1, 1'b1);
        sc(1'b0, 20, 1'b0);
        $display("modes test done");
    endtask
    // Status, mask and clear of the interrupt; both pulses at once
    task automatic t_irq();
        wr(win_switch_pkg::REG_IRQ_CLEAR, 32'h3);
        wr(win_switch_pkg::REG_IRQ_ENABLE, 32'h1);
        sc(1'b1, 1, 1'b0);
        rdchk("irq status", win_switch_pkg::REG_IRQ_STATUS, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        wr(win_switch_pkg::REG_IRQ_ENABLE, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 32'h1, {31'h0, irq});
        sc(1'b1, 20, 1'b1);
        rdchk("irq status", win_switch_pkg::REG_IRQ_STATUS, 32'h3);
        wr(win_switch_pkg::REG_IRQ_CLEAR, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        @(posedge clk);
        count_up <= 1'b1;
        count_down <= 1'b1;
        @(posedge clk);
        count_up <= 1'b0;
        count_down <= 1'b0;
        @(posedge clk);
        #1;
        chk("position", 32'h29, {16'h0, pos});
        // Sector event and clear in one cycle: the event stays
        @(posedge clk);
        count_down <= 1'b1;
        bus.wr <= 1'b1;
        bus.addr <= win_switch_pkg::REG_IRQ_CLEAR;
        bus.wdata <= 32'h3;
        @(posedge clk);
        count_down <= 1'b0;
        bus.wr <= 1'b0;
        rdchk("irq status", win_switch_pkg::REG_IRQ_STATUS, 32'h2);
        rdchk("state", win_switch_pkg::REG_STATE, 32'h1f);
        rdchk("ctrl", win_switch_pkg::REG_CTRL, 32'h2);
        $display("irq test done");
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        count_up = 1'b0;
        count_down = 1'b0;
        bus = '0;
        err_total = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_window();
        t_wrap();
        t_zero();
        t_modes();
        t_irq();
        test_done();
    end
endmodule // test_window_switch_channel_hysteresis
